// [verilog/pdi_pkg.sv]
// Constants shared by the page-mode memory controller and its helpers.
// Assumes a single 50 MHz core clock; all times are turned into cycle counts here.
package pdi_pkg;

  // ==========================================================================
  // Clock and conversion
  // ==========================================================================
  localparam int CLK_PERIOD_NS = 20;

  function automatic int cyc_min(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int cyc_max(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // ==========================================================================
  // Strobe timing, fastest grade, in ns; refresh and pause periods in us
  // ==========================================================================
  localparam int T_RAS_NS  = 40;   // Row strobe low time.
  localparam int T_RP_NS   = 25;   // Row precharge.
  localparam int T_RCD_NS  = 17;   // Row to column strobe delay.
  localparam int T_CAP_NS  = 34;   // Column precharge access, slowest grade limit.
  localparam int T_CP_NS   = 5;    // Column precharge.
  localparam int T_CSR_NS  = 10;   // Column setup before row, refresh.
  localparam int T_OED_NS  = 6;    // Output enable high to data driven.
  localparam int T_WP_NS   = 12;   // Write low before row rises.
  localparam int T_REF_US  = 8000; // Refresh period.
  localparam int T_PAUSE_US = 200; // Power-up pause.
  localparam int REF_ROWS  = 256;
  localparam int INIT_CYCLES = 8;

  // ==========================================================================
  // Cycle counts
  // ==========================================================================
  localparam int RAS_CYC = cyc_min(T_RAS_NS);
  localparam int RP_CYC  = cyc_min(T_RP_NS);
  localparam int RCD_CYC = cyc_min(T_RCD_NS);
  localparam int COL_CYC = cyc_min(T_CAP_NS);
  localparam int CP_CYC  = cyc_min(T_CP_NS);
  localparam int CSR_CYC = cyc_min(T_CSR_NS);
  localparam int OED_CYC = cyc_min(T_OED_NS);
  localparam int WP_CYC  = cyc_min(T_WP_NS);
  localparam int REF_INT_CYC = cyc_max(T_REF_US * 1000 / REF_ROWS);
  localparam int PAUSE_CYC_DEF = cyc_min(T_PAUSE_US * 1000);

  // ==========================================================================
  // Widths and address split
  // ==========================================================================
  localparam int ADDR_W  = 17;
  localparam int ROW_W   = 8;
  localparam int COL_W   = 9;
  localparam int PIN_W   = 9;
  localparam int DATA_W  = 16;
  localparam int TMR_W   = 16;
  localparam int OWED_W  = 4;

endpackage

// [verilog/pdi_timer.sv]
// Loadable down counter used for phase and interval timing.
// Assumes the caller loads it; done is high while the count is zero.
`timescale 1ns/100ps
module pdi_timer #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         core_clk_i,
  input  wire logic         rst_n_i,
  // Control
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  output logic              done_o
);
  logic [W-1:0] cnt;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i)
      cnt <= '0;
    else if (load_i)
      cnt <= load_val_i;
    else if (cnt != '0)
      cnt <= cnt - W'(1);
  end

  assign done_o = (cnt == '0);
endmodule // pdi_timer

// [verilog/pdi_refresh_tracker.sv]
// Power-up pause and refresh bookkeeping for the memory controller.
// Assumes refresh_done_i pulses once per refresh cycle issued by the caller.
`timescale 1ns/100ps
module pdi_refresh_tracker import pdi_pkg::*; #(
  parameter int PAUSE_CYC = PAUSE_CYC_DEF
) (
  // Clock and reset
  input  wire logic core_clk_i,
  input  wire logic rst_n_i,
  // Status
  input  wire logic refresh_done_i,
  output logic      pause_done_o,
  output logic      refresh_due_o
);
  logic              int_done;
  logic              int_tick;
  logic [OWED_W-1:0] owed;
  logic [OWED_W-1:0] next_owed;

  logic [TMR_W-1:0] pause_cnt;
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i)
      pause_cnt <= TMR_W'(PAUSE_CYC);
    else if (pause_cnt != '0)
      pause_cnt <= pause_cnt - TMR_W'(1);
  end
  assign pause_done_o = (pause_cnt == '0);

  // One tick per refresh slot; the interval timer reloads itself.
  pdi_timer #(.W(TMR_W)) u_interval (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (int_done),
    .load_val_i (TMR_W'(REF_INT_CYC - 1)),
    .done_o     (int_done)
  );
  assign int_tick = int_done && pause_done_o;

  // A tick in the same cycle as a completed refresh leaves the count as is.
  assign next_owed = (int_tick && !refresh_done_i && owed != '1) ? owed + OWED_W'(1) :
                     (!int_tick && refresh_done_i && owed != '0) ? owed - OWED_W'(1) :
                     owed;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i)
      owed <= '0;
    else
      owed <= next_owed;
  end

  assign refresh_due_o = (owed != '0);
endmodule // pdi_refresh_tracker

// [verilog/pdi_ctrl.sv]
// Host controller that drives a 128K x 16 page-mode dynamic memory by its strobes.
// Assumes one 50 MHz clock, a synchronous active-low reset and a data bus
// resolved outside from dq_o and dq_oe_o.
//
// Function
// RULE1: Split 17-bit address into 8-bit row then 9-bit column on pins.
// RULE2: Device latches row on row strobe fall, column on column strobe fall.
// RULE3: Every cycle starts with row strobe low held at least minimum pulse.
// RULE4: Wait row precharge, or column precharge in page mode, before new cycle.
// RULE5: Reads keep write enable high and output enable low.
// RULE6: Read data sampled only after the longest column access delay.
// RULE7: Write enable stays high past column strobe rise in reads.
// RULE8: Lower lane strobe alone with write low writes only lower byte.
// RULE9: Upper lane strobe alone with write low writes only upper byte.
// RULE10: Only the enabled lane strobes fall; the other lane stays idle.
// RULE11: Early write drops write enable before column strobe falls.
// RULE12: Write data valid from column fall and held after it.
// RULE13: Write enable low well before row strobe rises in writes.
// RULE14: Output enable high at least one gap before driving write data.
// RULE15: Read-modify-write keeps long row low time and total cycle.
// RULE16: In read-modify-write, write enable falls only after read data out.
// RULE17: Page mode keeps row low across column cycles of minimum period.
// RULE18: Last column address stands long before row strobe rises.
// RULE19: Column-first refresh: column low before and after row strobe fall.
// RULE20: Issue 256 refreshes every 8 ms.
// RULE21: After power-up wait 200 us then run 8 row cycles.
// RULE22: Row-only refresh refreshes the presented row with data pins idle.
// RULE23: Column-first refresh uses the device's own row counter.
`timescale 1ns/100ps
module pdi_ctrl import pdi_pkg::*; #(
  parameter int PAUSE_CYC = PAUSE_CYC_DEF
) (
  // Clock and reset
  input  wire logic              core_clk_i,
  input  wire logic              rst_n_i,
  // Request port
  input  wire logic              req_valid_i,
  output logic                   req_ready_o,
  input  wire logic              req_write_i,
  input  wire logic              req_rmw_i,
  input  wire logic [ADDR_W-1:0] req_addr_i,
  input  wire logic [1:0]        req_be_i,
  input  wire logic [DATA_W-1:0] req_wdata_i,
  // Response port
  output logic                   rsp_valid_o,
  output logic [DATA_W-1:0]      rsp_rdata_o,
  output logic                   init_done_o,
  // Memory pins
  output logic                   row_strobe_n_o,
  output logic                   lower_lane_col_strobe_n_o,
  output logic                   upper_lane_col_strobe_n_o,
  output logic                   write_en_n_o,
  output logic                   out_en_n_o,
  output logic [PIN_W-1:0]       mem_addr_o,
  input  wire logic [DATA_W-1:0] dq_i,
  output logic [DATA_W-1:0]      dq_o,
  output logic                   dq_oe_o
);

  // ==========================================================================
  // State and request holding
  // ==========================================================================
  typedef enum logic [3:0] {
    ST_INIT_PAUSE, ST_INIT_ROW, ST_INIT_PRE, ST_IDLE, ST_CBR_SETUP, ST_CBR_ROW,
    ST_ROW_ACT, ST_COL_SETUP, ST_COL_LOW, ST_RMW_OE, ST_RMW_WE, ST_COL_PRE,
    ST_PRECHARGE
  } pdi_state_e;

  pdi_state_e        state;
  pdi_state_e        next_state;
  logic              tmr_done;
  logic [TMR_W-1:0]  tmr_val;
  logic              pause_done;
  logic              refresh_due;
  logic              refresh_done;
  logic [2:0]        init_cnt;
  logic [ADDR_W-1:0] cur_addr;
  logic [1:0]        cur_be;
  logic [DATA_W-1:0] cur_wdata;
  logic              cur_write;
  logic              cur_rmw;

  // Effective request: the one being taken this cycle, else the held one.
  logic              accept;
  logic              page_hit;
  logic [ADDR_W-1:0] eff_addr;
  logic [1:0]        eff_be;
  logic              eff_write;
  logic              eff_rmw;
  logic [DATA_W-1:0] eff_wdata;

  // Rows stay open only while the next request already waits on them, so the
  // row strobe never lingers near its upper limit.
  assign page_hit = (req_addr_i[ADDR_W-1 -: ROW_W] == cur_addr[ADDR_W-1 -: ROW_W]); // RULE17
  assign req_ready_o = tmr_done && !refresh_due &&
                       ((state == ST_IDLE) || (state == ST_COL_PRE && page_hit));
  assign accept    = req_valid_i && req_ready_o;
  assign eff_addr  = accept ? req_addr_i : cur_addr;
  assign eff_be    = accept ? req_be_i : cur_be;
  assign eff_rmw   = accept ? req_rmw_i : cur_rmw;
  assign eff_write = accept ? (req_write_i && !req_rmw_i) : cur_write;
  assign eff_wdata = accept ? req_wdata_i : cur_wdata;

  // ==========================================================================
  // Helpers
  // ==========================================================================
  pdi_timer #(.W(TMR_W)) u_phase (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (tmr_done),
    .load_val_i (tmr_val),
    .done_o     (tmr_done)
  );

  pdi_refresh_tracker #(.PAUSE_CYC(PAUSE_CYC)) u_refresh (
    .core_clk_i     (core_clk_i),
    .rst_n_i        (rst_n_i),
    .refresh_done_i (refresh_done),
    .pause_done_o   (pause_done),
    .refresh_due_o  (refresh_due)
  );

  // ==========================================================================
  // Sequencing
  // ==========================================================================
  function automatic logic [TMR_W-1:0] phase_len(input pdi_state_e s);
    int n;
    n = 1;
    unique case (s)
      ST_INIT_ROW, ST_CBR_ROW:  n = RAS_CYC;  // RULE3
      ST_INIT_PRE, ST_PRECHARGE: n = RP_CYC;  // RULE4
      ST_ROW_ACT:               n = RCD_CYC;
      ST_COL_LOW:               n = COL_CYC;  // RULE6
      ST_COL_PRE:               n = CP_CYC;   // RULE4
      ST_CBR_SETUP:             n = CSR_CYC;  // RULE19
      ST_RMW_OE:                n = OED_CYC;  // RULE14
      ST_RMW_WE:                n = WP_CYC;   // RULE13
      ST_INIT_PAUSE, ST_IDLE, ST_COL_SETUP: n = 1;
    endcase
    return TMR_W'(n - 1);
  endfunction

  always_comb begin
    next_state = state;
    if (tmr_done) begin
      unique case (state)
        ST_INIT_PAUSE: if (pause_done) next_state = ST_INIT_ROW;               // RULE21
        ST_INIT_ROW:   next_state = ST_INIT_PRE;                               // RULE22
        ST_INIT_PRE:   next_state = (init_cnt == 3'(INIT_CYCLES - 1)) ? ST_IDLE
                                                                      : ST_INIT_ROW; // RULE21
        ST_IDLE:       if (refresh_due) next_state = ST_CBR_SETUP;             // RULE20
                       else if (accept) next_state = ST_ROW_ACT;
        ST_CBR_SETUP:  next_state = ST_CBR_ROW;
        ST_CBR_ROW:    next_state = ST_PRECHARGE;
        ST_ROW_ACT:    next_state = ST_COL_SETUP;
        ST_COL_SETUP:  next_state = ST_COL_LOW;
        ST_COL_LOW:    next_state = cur_rmw ? ST_RMW_OE : ST_COL_PRE;  // RULE15 RULE16
        ST_RMW_OE:     next_state = ST_RMW_WE;
        ST_RMW_WE:     next_state = ST_COL_PRE;
        ST_COL_PRE:    next_state = accept ? ST_COL_SETUP : ST_PRECHARGE;     // RULE17
        ST_PRECHARGE:  next_state = ST_IDLE;
      endcase
    end
  end

  assign tmr_val      = phase_len(next_state);
  assign refresh_done = tmr_done && (state == ST_CBR_ROW);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      state    <= ST_INIT_PAUSE;
      init_cnt <= '0;
    end else begin
      state <= next_state;
      if (tmr_done && state == ST_INIT_PRE)
        init_cnt <= init_cnt + 3'(1);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      cur_addr  <= '0;
      cur_be    <= '0;
      cur_wdata <= '0;
      cur_write <= 1'b0;
      cur_rmw   <= 1'b0;
    end else if (accept) begin
      cur_addr  <= eff_addr;
      cur_be    <= eff_be;
      cur_wdata <= eff_wdata;
      cur_write <= eff_write;
      cur_rmw   <= eff_rmw;
    end
  end

  // ==========================================================================
  // Pin decode from the coming state
  // ==========================================================================
  logic             ns_row_low;
  logic             ns_cbr;
  logic             ns_col_data;
  logic             ns_col_low;
  logic             ns_we_low;
  logic             ns_oe_low;
  logic [PIN_W-1:0] ns_addr;

  assign ns_row_low  = !(next_state inside {ST_INIT_PAUSE, ST_INIT_PRE, ST_IDLE,
                                            ST_CBR_SETUP, ST_PRECHARGE});   // RULE3
  assign ns_cbr      = next_state inside {ST_CBR_SETUP, ST_CBR_ROW};        // RULE19
  assign ns_col_data = next_state inside {ST_COL_SETUP, ST_COL_LOW};
  assign ns_col_low  = next_state inside {ST_COL_LOW, ST_RMW_OE, ST_RMW_WE};
  assign ns_we_low   = (eff_write && ns_col_data) || (next_state == ST_RMW_WE); // RULE11
  assign ns_oe_low   = !eff_write && ns_col_data;                            // RULE5
  // The row goes out in the low pins with the top pin low; the device's own
  // counter supplies rows in column-first refresh, so the pins idle at zero.
  assign ns_addr = (next_state == ST_ROW_ACT) ?
                     {1'b0, eff_addr[ADDR_W-1 -: ROW_W]} :                   // RULE1
                   (next_state == ST_INIT_ROW) ? {6'h00, init_cnt} :
                   ns_cbr ? '0 : eff_addr[COL_W-1:0];                        // RULE18

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      row_strobe_n_o            <= 1'b1;
      lower_lane_col_strobe_n_o <= 1'b1;
      upper_lane_col_strobe_n_o <= 1'b1;
      write_en_n_o              <= 1'b1;
      out_en_n_o                <= 1'b1;
      mem_addr_o                <= '0;
      dq_o                      <= '0;
      dq_oe_o                   <= 1'b0;
    end else begin
      row_strobe_n_o            <= !ns_row_low;
      lower_lane_col_strobe_n_o <= !(ns_cbr || (ns_col_low && eff_be[0])); // RULE10
      upper_lane_col_strobe_n_o <= !(ns_cbr || (ns_col_low && eff_be[1])); // RULE10
      write_en_n_o              <= !ns_we_low;
      out_en_n_o                <= !ns_oe_low;
      mem_addr_o                <= ns_addr;
      dq_o                      <= eff_wdata;                              // RULE12
      dq_oe_o                   <= ns_we_low;                              // RULE14
    end
  end

  // ==========================================================================
  // Read capture
  // ==========================================================================
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= '0;
      init_done_o <= 1'b0;
    end else begin
      rsp_valid_o <= tmr_done && state == ST_COL_LOW && !cur_write;        // RULE6
      if (tmr_done && state == ST_COL_LOW && !cur_write)
        rsp_rdata_o <= dq_i;
      init_done_o <= init_done_o || (tmr_done && next_state == ST_IDLE);
    end
  end

  // ==========================================================================
  // Checks
  // ==========================================================================
  localparam int CHK_RAS = RAS_CYC;
  localparam int CHK_RP  = RP_CYC;
  logic [7:0] row_low_cnt;
  logic [7:0] row_high_cnt;
  logic [7:0] col_low_cnt;
  logic       col_any_n;

  assign col_any_n = lower_lane_col_strobe_n_o && upper_lane_col_strobe_n_o;

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      row_low_cnt  <= '0;
      row_high_cnt <= 8'hff;
      col_low_cnt  <= '0;
    end else begin
      row_low_cnt  <= row_strobe_n_o ? 8'h00 : row_low_cnt + 8'(row_low_cnt != 8'hff);
      row_high_cnt <= !row_strobe_n_o ? 8'h00 : row_high_cnt + 8'(row_high_cnt != 8'hff);
      col_low_cnt  <= col_any_n ? 8'h00 : col_low_cnt + 8'(col_low_cnt != 8'hff);
    end
  end

  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence row_rise_s;
    $rose(row_strobe_n_o);
  endsequence
  sequence cbr_start_s;
    $fell(row_strobe_n_o) && !col_any_n;
  endsequence
  sequence rmw_write_s;
    $fell(write_en_n_o) && !col_any_n;
  endsequence

  // The counters already hold the edge that ended the phase, so no past value is taken.
  row_pulse_a: assert property (row_rise_s |-> row_low_cnt >= CHK_RAS) // RULE3
    else $error("Row strobe low time too short.");
  row_precharge_a: assert property ($fell(row_strobe_n_o) |->
      row_high_cnt >= CHK_RP) // RULE4
    else $error("Row precharge too short.");
  read_enable_a: assert property ($rose(col_any_n) && $past(!out_en_n_o) |->
      write_en_n_o && $past(write_en_n_o)) // RULE7
    else $error("Write enable low during a read.");
  early_write_a: assert property ($fell(col_any_n) && !write_en_n_o |->
      $past(!write_en_n_o) && out_en_n_o && dq_oe_o) // RULE11
    else $error("Early write set up too late.");
  rmw_delay_a: assert property (rmw_write_s |->
      $past(col_low_cnt) >= 8'(COL_CYC) && out_en_n_o) // RULE16
    else $error("Write enable fell before read data.");
  oe_gap_a: assert property ($rose(dq_oe_o) && !col_any_n |->
      out_en_n_o && $past(out_en_n_o)) // RULE14
    else $error("Data driven without output enable gap.");
  cbr_order_a: assert property (cbr_start_s |-> $past(!col_any_n) ##1 !col_any_n) // RULE19
    else $error("Column-first refresh order broken.");
  read_wait_a: assert property (rsp_valid_o |->
      col_low_cnt >= 8'(COL_CYC) && $past(!out_en_n_o)) // RULE6
    else $error("Read data sampled early.");
  row_addr_a: assert property ($fell(row_strobe_n_o) && col_any_n |->
      !mem_addr_o[PIN_W-1]) // RULE1
    else $error("Row part uses the ninth pin.");
  init_hold_a: assert property (!init_done_o && !row_strobe_n_o |->
      state inside {ST_INIT_ROW, ST_INIT_PRE}) // RULE21
    else $error("Access before initialisation.");

  rmw_row_a: assert property (rmw_write_s |->
      row_low_cnt > 8'(RAS_CYC) ##1 !row_strobe_n_o) // RULE15
    else $error("Row strobe rose inside a read-modify-write.");
  write_data_a: assert property (!write_en_n_o && !col_any_n |->
      dq_oe_o && $stable(dq_o)) // RULE12
    else $error("Write data not steady while written.");
  read_oe_a: assert property ($fell(out_en_n_o) |-> write_en_n_o) // RULE5
    else $error("Output enable low with write enable low.");
  cas_precharge_a: assert property ($fell(col_any_n) && !row_strobe_n_o |->
      $past(col_any_n, 2)) // RULE4
    else $error("Column precharge too short.");
  // An owed refresh must not wait behind a page burst; rows close once it is due.
  refresh_slot_a: assert property ($rose(refresh_due) |-> ##[1:32] refresh_done) // RULE20
    else $error("Owed refresh not issued in time.");

endmodule // pdi_ctrl

// [sim/pdi_mem_model.sv]
// Behavioural page-mode memory driven by its strobes, with timing checks on the controller.
// Assumes strobes move only on controller clock edges; viol counts broken timings.
`timescale 1ns/100ps
module pdi_mem_model import pdi_pkg::*; (
  // Strobes
  input  wire logic              row_n_i,
  input  wire logic              lo_n_i,
  input  wire logic              up_n_i,
  input  wire logic              we_n_i,
  input  wire logic              oe_n_i,
  // Address and data
  input  wire logic [PIN_W-1:0]  addr_i,
  input  wire logic [DATA_W-1:0] wd_i,
  input  wire logic              wd_oe_i,
  output logic [DATA_W-1:0]      rd_o
);
  // ====================
  // Storage and read path
  // ====================
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic [ROW_W-1:0]  row = '0, ref_row = '0;
  logic [COL_W-1:0]  col = '0;
  logic              acc = 0, column_first_refresh = 0, wr = 0, rmw = 0;
  int                n_ras = 0, n_ref = 0, viol = 0;
  realtime           t_rf = -1e3, t_rr = -1e3, t_cf = -1e3;
  realtime           t_cr = -1e3, t_wf = -1e3, t_oer = -1e3;
  wire [DATA_W-1:0]  cur = mem[{row, col}];
  wire lo_on = !row_n_i && !lo_n_i && we_n_i && !oe_n_i && acc;
  wire up_on = !row_n_i && !up_n_i && we_n_i && !oe_n_i && acc;
  // Idle lanes show the inverse of the cell, so a stale lane is never taken for data.
  assign rd_o = {up_on ? cur[15:8] : ~cur[15:8], lo_on ? cur[7:0] : ~cur[7:0]};
  task automatic put(input logic lo, input logic up);
    if (!wd_oe_i || !oe_n_i) viol++;
    if (lo) mem[{row, col}][7:0] = wd_i[7:0];
    if (up) mem[{row, col}][15:8] = wd_i[15:8];
    wr = 1;
  endtask
  task automatic col_fall(input logic lo, input logic up);
    if ($realtime - t_cr < T_CP_NS) viol++;
    #1;
    col = addr_i;
    if (!we_n_i) put(lo, up);
    #(T_CAP_NS - 1);
    if (!lo_n_i || !up_n_i) acc = 1;
  endtask
  // ====================
  // Strobe edges
  // ====================
  always @(negedge lo_n_i or negedge up_n_i) t_cf = $realtime;
  always @(negedge lo_n_i) if (!row_n_i) col_fall(1'b1, 1'b0);
  always @(negedge up_n_i) if (!row_n_i) col_fall(1'b0, 1'b1);
  always @(posedge lo_n_i or posedge up_n_i) begin
    t_cr = $realtime;
    acc = 0;
    if (column_first_refresh && $realtime - t_rf < 8) viol++;
  end
  always @(negedge row_n_i) begin
    if ($realtime - t_rr < T_RP_NS) viol++;
    t_rf = $realtime;
    n_ras++;
    n_ref++;
    #1;
    column_first_refresh = !lo_n_i || !up_n_i;
    if (column_first_refresh && t_rf - t_cf < T_CSR_NS) viol++;
    row = column_first_refresh ? ref_row : addr_i[ROW_W-1:0];
    if (column_first_refresh) ref_row++;
  end
  always @(posedge row_n_i) begin
    if ($realtime - t_rf < T_RAS_NS) viol++;
    if (wr && $realtime - t_wf < T_WP_NS) viol++;
    if (rmw && $realtime - t_rf < 75) viol++;
    t_rr = $realtime;
    wr = 0;
    rmw = 0;
    column_first_refresh = 0;
  end
  always @(negedge we_n_i) begin
    t_wf = $realtime;
    #1;
    if (!row_n_i && (!lo_n_i || !up_n_i)) begin
      if (t_wf - t_cf < 30 || t_wf - t_rf < 58) viol++;
      rmw = 1;
      put(!lo_n_i, !up_n_i);
    end
  end
  always @(posedge oe_n_i) t_oer = $realtime;
  always @(posedge wd_oe_i) if (!oe_n_i || $realtime - t_oer < T_OED_NS) viol++;
endmodule // pdi_mem_model

// [sim/tb.sv]
// Self-checking bench for the page-mode memory controller against a behavioural memory.
// Assumes the memory model counts broken strobe timings in its viol counter.
`timescale 1ns/100ps
module tb import pdi_pkg::*;;
  localparam int PAUSE = 20;
  localparam int LIMIT = 2 * REF_INT_CYC + 1000;
  // ====================
  // Wiring
  // ====================
  logic              core_clk_i = 0, rst_n_i = 0, req_valid_i = 0, req_write_i = 0;
  logic              req_rmw_i = 0;
  logic [ADDR_W-1:0] req_addr_i = '0;
  logic [1:0]        req_be_i = '0;
  logic [DATA_W-1:0] req_wdata_i = '0;
  logic              req_ready_o, rsp_valid_o, init_done_o, row_strobe_n_o, write_en_n_o;
  logic              lower_lane_col_strobe_n_o, upper_lane_col_strobe_n_o, out_en_n_o, dq_oe_o;
  logic [PIN_W-1:0]  mem_addr_o;
  logic [DATA_W-1:0] rsp_rdata_o, dq_i, dq_o, tmp;
  int                bad_count = 0, n_compared = 0, cyc = 0, rel = 0, first = 0, n0;
  logic [DATA_W-1:0] rq[$];
  pdi_ctrl #(.PAUSE_CYC(PAUSE)) pdi_ctrl_i (.core_clk_i, .rst_n_i, .req_valid_i, .req_ready_o,
    .req_write_i, .req_rmw_i, .req_addr_i, .req_be_i, .req_wdata_i, .rsp_valid_o, .rsp_rdata_o,
    .init_done_o, .row_strobe_n_o, .lower_lane_col_strobe_n_o, .upper_lane_col_strobe_n_o,
    .write_en_n_o, .out_en_n_o, .mem_addr_o, .dq_i, .dq_o, .dq_oe_o);
  pdi_mem_model pdi_mem_model_i (.row_n_i(row_strobe_n_o), .lo_n_i(lower_lane_col_strobe_n_o),
    .up_n_i(upper_lane_col_strobe_n_o), .we_n_i(write_en_n_o), .oe_n_i(out_en_n_o),
    .addr_i(mem_addr_o), .wd_i(dq_o), .wd_oe_i(dq_oe_o), .rd_o(dq_i));
  // ====================
  // Shared tasks
  // ====================
  task automatic results;
    if (bad_count == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic issue(input logic w, input logic m, input logic [ADDR_W-1:0] a,
                       input logic [1:0] be, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    req_valid_i <= 1'b1;
    req_write_i <= w;
    req_rmw_i <= m;
    req_addr_i <= a;
    req_be_i <= be;
    req_wdata_i <= d;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (req_ready_o !== 1'b1 && n < 500);
    if (n >= 500) check("request taken", 0, 1);
  endtask
  task automatic idle;
    req_valid_i <= 1'b0;
    @(posedge core_clk_i);
  endtask
  // Responses are checked in order; a missing one reads as unknown and fails.
  task automatic get(input string what, input logic [DATA_W-1:0] exp, input logic [DATA_W-1:0] m);
    int n;
    n = 0;
    while (rq.size() == 0 && n < 50) begin
      @(posedge core_clk_i);
      n++;
    end
    tmp = (rq.size() > 0) ? rq.pop_front() : 'x;
    check(what, tmp & m, exp & m);
  endtask
  always @(posedge core_clk_i) begin
    cyc++;
    if (rsp_valid_o === 1'b1) rq.push_back(rsp_rdata_o);
    if (cyc == LIMIT) begin
      bad_count++;
      results();
    end
  end
  always @(negedge row_strobe_n_o) if (first == 0) first = cyc;
  initial begin
    forever #10 core_clk_i = ~core_clk_i;
  end
  // ====================
  // Scenarios
  // ====================
  task automatic t_init;
    n0 = 0;
    while (init_done_o !== 1'b1 && n0 < 500) begin
      @(posedge core_clk_i);
      n0++;
    end
    check("pause before first row", first - rel >= PAUSE, 1);
    check("init row cycles", pdi_mem_model_i.n_ras, INIT_CYCLES);
  endtask
  task automatic t_word;
    issue(1, 0, 17'h1a5c3, 2'b11, 16'h3c96);
    idle();
    issue(0, 0, 17'h1a5c3, 2'b11, '0);
    idle();
    get("word read", 16'h3c96, 16'hffff);
    check("row column split", pdi_mem_model_i.mem[17'h1a5c3], 16'h3c96);
  endtask
  // Back-to-back accesses in one row must share a single row strobe.
  task automatic t_bytes;
    issue(1, 0, 17'h0035a, 2'b11, 16'h1111);
    n0 = pdi_mem_model_i.n_ras;
    issue(1, 0, 17'h0035a, 2'b01, 16'haabb);
    issue(1, 0, 17'h0035b, 2'b10, 16'hccdd);
    issue(0, 0, 17'h0035a, 2'b11, '0);
    issue(0, 0, 17'h0035b, 2'b10, '0);
    idle();
    get("lower lane write", 16'h11bb, 16'hffff);
    get("upper lane write", 16'hcc00, 16'hff00);
    check("rows opened in page", pdi_mem_model_i.n_ras - n0, 1);
  endtask
  task automatic t_rmw;
    issue(0, 1, 17'h0035a, 2'b11, 16'h5a5a);
    n0 = pdi_mem_model_i.n_ras;
    issue(0, 0, 17'h1a5c3, 2'b11, '0);
    issue(0, 0, 17'h0035a, 2'b11, '0);
    idle();
    get("old data from rmw", 16'h11bb, 16'hffff);
    get("other row read", 16'h3c96, 16'hffff);
    get("data after rmw", 16'h5a5a, 16'hffff);
    check("rows opened across rows", pdi_mem_model_i.n_ras - n0, 3);
  endtask
  task automatic t_refresh;
    n0 = pdi_mem_model_i.n_ref;
    repeat (2 * REF_INT_CYC + 50) @(posedge core_clk_i);
    n0 = pdi_mem_model_i.n_ref - n0;
    check("refreshes over two intervals", n0 >= 2 && n0 <= 3, 1);
    issue(0, 0, 17'h1a5c3, 2'b11, '0);
    idle();
    get("data kept over refresh", 16'h3c96, 16'hffff);
    check("strobe timing faults", pdi_mem_model_i.viol, 0);
  endtask
  initial begin
    repeat (10) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    rel = cyc;
    t_init();
    t_word();
    t_bytes();
    t_rmw();
    t_refresh();
    results();
  end
endmodule // tb
